/* File: hw/hmbx_pkg.sv */
package hmbx_pkg;

  // ---------------------------------------------------------------
  // port numbering
  // ---------------------------------------------------------------
  localparam int         NUM_PORTS  = 3;
  localparam logic [1:0] PORT_KBD   = 2'h0;
  localparam logic [1:0] PORT_PWR1  = 2'h1;
  localparam logic [1:0] PORT_PWR2  = 2'h2;

  // ---------------------------------------------------------------
  // local controller register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] KBD_PORT_STATUS            = 8'hAD;
  localparam logic [7:0] KBD_PORT_INPUT_BYTE        = 8'hAE;
  localparam logic [7:0] KBD_PORT_OUTPUT_BYTE       = 8'hAF;
  localparam logic [7:0] POWER_PORT_ONE_STATUS      = 8'hBD;
  localparam logic [7:0] POWER_PORT_ONE_INPUT_BYTE  = 8'hBE;
  localparam logic [7:0] POWER_PORT_ONE_OUTPUT_BYTE = 8'hBF;
  localparam logic [7:0] POWER_PORT_TWO_STATUS      = 8'hF5;
  localparam logic [7:0] POWER_PORT_TWO_INPUT_BYTE  = 8'hF6;
  localparam logic [7:0] POWER_PORT_TWO_OUTPUT_BYTE = 8'hF7;

  // ---------------------------------------------------------------
  // status byte layout
  // ---------------------------------------------------------------
  localparam int         STAT_OUTPUT_FULL = 0;
  localparam int         STAT_INPUT_FULL  = 1;
  localparam int         STAT_COMMAND_TAG = 3;
  localparam logic [7:0] STAT_USER_MASK   = 8'hF4;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;

  // register kinds inside one port
  typedef enum logic [1:0] {
    HMBX_REG_NONE,
    HMBX_REG_STATUS,
    HMBX_REG_INPUT,
    HMBX_REG_OUTPUT
  } hmbx_reg_type;

endpackage

/* File: hw/hmbx_host_mailbox_ports.sv */
`timescale 1ns/1ns
`default_nettype none

module hmbx_host_mailbox_ports #(
  parameter int DATA_W    = 8,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // host side parallel bus
  input  wire logic              kbd_port_select_n,
  input  wire logic              power_one_port_select_n,
  input  wire logic              power_two_port_select_n,
  input  wire logic              host_a0,
  input  wire logic              host_rd_n,
  input  wire logic              host_wr_n,
  input  wire logic [DATA_W-1:0] host_data_in,
  output logic      [DATA_W-1:0] host_data_out,
  output logic                   host_data_oe,
  output logic                   host_write_ready,
  output logic                   kbd_output_full_host_irq_pin,
  output logic                   power_one_host_irq_pin_n,
  output logic                   power_two_host_irq_pin_n,
  // local controller register bus
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr_en,
  input  wire logic              sfr_rd_en,
  input  wire logic [DATA_W-1:0] sfr_wdata,
  output logic      [DATA_W-1:0] sfr_rdata,
  // controller interrupt enables and requests
  input  wire logic              kbd_input_irq_enable,
  input  wire logic              power_one_input_irq_enable,
  input  wire logic              power_two_input_irq_enable,
  output logic                   kbd_input_irq,
  output logic                   power_one_input_irq,
  output logic                   power_two_input_irq
);

  // three identical ports share one decode and one write buffer; the
  // entry width packs port number, command tag and byte so that a
  // stalled drain still knows where each byte belongs
  // pointers carry one extra bit to tell full from empty
  localparam int NP    = hmbx_pkg::NUM_PORTS;
  localparam int ENT_W = 2 + 1 + DATA_W;
  localparam int PTR_W = $clog2(BUF_DEPTH) + 1;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // decode used for both read and write paths
  // an unmapped address decodes to no register kind, so reads return
  // zero and writes fall through without touching any port; the port
  // field is then a don't-care
  function automatic logic [3:0] sfr_decode(input logic [7:0] addr);
    case (addr)
      hmbx_pkg::KBD_PORT_STATUS:
        sfr_decode = {hmbx_pkg::PORT_KBD, hmbx_pkg::HMBX_REG_STATUS};
      hmbx_pkg::KBD_PORT_INPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_KBD, hmbx_pkg::HMBX_REG_INPUT};
      hmbx_pkg::KBD_PORT_OUTPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_KBD, hmbx_pkg::HMBX_REG_OUTPUT};
      hmbx_pkg::POWER_PORT_ONE_STATUS:
        sfr_decode = {hmbx_pkg::PORT_PWR1, hmbx_pkg::HMBX_REG_STATUS};
      hmbx_pkg::POWER_PORT_ONE_INPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_PWR1, hmbx_pkg::HMBX_REG_INPUT};
      hmbx_pkg::POWER_PORT_ONE_OUTPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_PWR1, hmbx_pkg::HMBX_REG_OUTPUT};
      hmbx_pkg::POWER_PORT_TWO_STATUS:
        sfr_decode = {hmbx_pkg::PORT_PWR2, hmbx_pkg::HMBX_REG_STATUS};
      hmbx_pkg::POWER_PORT_TWO_INPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_PWR2, hmbx_pkg::HMBX_REG_INPUT};
      hmbx_pkg::POWER_PORT_TWO_OUTPUT_BYTE:
        sfr_decode = {hmbx_pkg::PORT_PWR2, hmbx_pkg::HMBX_REG_OUTPUT};
      default:
        sfr_decode = {hmbx_pkg::PORT_KBD, hmbx_pkg::HMBX_REG_NONE};
    endcase
  endfunction

  wire logic [3:0]             dec_word = sfr_decode(sfr_addr);
  wire logic [1:0]             dec_port = dec_word[3:2];
  wire hmbx_pkg::hmbx_reg_type dec_kind = hmbx_pkg::hmbx_reg_type'(dec_word[1:0]);

  // ---------------------------------------------------------------
  // per-port storage
  // ---------------------------------------------------------------
  // bytes, tags and user bits have no reset: they power up unknown and
  // keep their contents through any reset, so firmware must not trust
  // them before the first write; only the two full flags are reset
  logic [DATA_W-1:0] input_byte_r  [NP];
  logic [DATA_W-1:0] output_byte_r [NP];
  logic [DATA_W-1:0] user_status_r [NP];
  logic              command_tag_r [NP];
  logic              input_full_r  [NP];
  logic              output_full_r [NP];
  logic [DATA_W-1:0] status_byte   [NP];

  // ---------------------------------------------------------------
  // host bus decode and strobe edges
  // ---------------------------------------------------------------
  logic       host_wr_n_r;
  logic       host_rd_n_r;
  logic [1:0] host_port;
  logic       host_sel_one;

  // host pins are taken as synchronous to mclk, so no synchroniser
  // stands here; a host on another clock would need one in front
  // exactly one select low picks a port; none or several are ignored
  wire logic [2:0] sel_vec = {~power_two_port_select_n,
                              ~power_one_port_select_n,
                              ~kbd_port_select_n};
  always_comb begin
    host_sel_one = 1'b1;
    host_port    = hmbx_pkg::PORT_KBD;
    case (sel_vec)
      3'h1:    host_port = hmbx_pkg::PORT_KBD;
      3'h2:    host_port = hmbx_pkg::PORT_PWR1;
      3'h4:    host_port = hmbx_pkg::PORT_PWR2;
      default: host_sel_one = 1'b0;
    endcase
  end

  // taking the trailing edge lets select, A0 and data settle for the
  // whole strobe; the cost is one cycle of latency per transfer
  // strobes are taken on their trailing (rising) edge, while select is held
  wire logic host_wr_end = ~host_wr_n_r & host_wr_n & host_sel_one;
  wire logic host_rd_end = ~host_rd_n_r & host_rd_n & host_sel_one;
  wire logic host_rd_act = ~host_rd_n & host_sel_one;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_wr_n_r <= 1'b1;
      host_rd_n_r <= 1'b1;
    end else begin
      host_wr_n_r <= host_wr_n;
      host_rd_n_r <= host_rd_n;
    end
  end

  // ---------------------------------------------------------------
  // two-entry buffer for host writes
  // ---------------------------------------------------------------
  // the buffer absorbs a host write that arrives while the drain is
  // held off by a controller read of the same input byte; a write that
  // completes while host_write_ready is low is lost, as overrun is
  // undefined for the host anyway
  // entry: port, A0 tag, data byte
  logic [ENT_W-1:0] buf_mem_r [BUF_DEPTH];
  logic [PTR_W-1:0] buf_wptr_r;
  logic [PTR_W-1:0] buf_rptr_r;

  wire logic [PTR_W-2:0] buf_widx  = buf_wptr_r[PTR_W-2:0];
  wire logic [PTR_W-2:0] buf_ridx  = buf_rptr_r[PTR_W-2:0];
  wire logic             buf_empty = (buf_wptr_r == buf_rptr_r);
  wire logic             buf_full  = (buf_widx == buf_ridx) &&
                                     (buf_wptr_r[PTR_W-1] != buf_rptr_r[PTR_W-1]);
  wire logic             buf_in_valid = host_wr_end;
  wire logic             buf_in_ready = ~buf_full;
  wire logic             buf_push     = buf_in_valid & buf_in_ready;

  wire logic [ENT_W-1:0]  head        = buf_mem_r[buf_ridx];
  wire logic [1:0]        head_port   = head[ENT_W-1:ENT_W-2];
  wire logic              head_tag    = head[DATA_W];
  wire logic [DATA_W-1:0] head_data   = head[DATA_W-1:0];
  wire logic              buf_out_valid = ~buf_empty;

  // the drain stalls while the controller reads the same input byte,
  // so a fresh byte is never swallowed by a read of the old one
  wire logic sfr_in_read  = sfr_rd_en && (dec_kind == hmbx_pkg::HMBX_REG_INPUT);
  wire logic buf_out_ready = ~(sfr_in_read && (dec_port == head_port));
  wire logic buf_pop       = buf_out_valid & buf_out_ready;

  assign host_write_ready = buf_in_ready;

  // a reset empties the buffer, so a byte still in flight is dropped
  // pointers only; the entries themselves need no reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wptr_r <= '0;
      buf_rptr_r <= '0;
    end else begin
      buf_wptr_r <= buf_wptr_r + PTR_W'(buf_push);
      buf_rptr_r <= buf_rptr_r + PTR_W'(buf_pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (buf_push) begin
      buf_mem_r[buf_widx] <= {host_port, host_a0, host_data_in};
    end
  end

  // ---------------------------------------------------------------
  // per-port registers and flags
  // ---------------------------------------------------------------
  // one copy of the port logic per port; the loop index doubles as the
  // port number that the decode and the buffer entry carry
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      wire logic here_drain = buf_pop && (head_port == 2'(gp));
      wire logic here_sfr   = (dec_port == 2'(gp));
      wire logic in_rd      = sfr_in_read && here_sfr;
      wire logic out_wr     = sfr_wr_en && here_sfr &&
                              (dec_kind == hmbx_pkg::HMBX_REG_OUTPUT);
      wire logic stat_wr    = sfr_wr_en && here_sfr &&
                              (dec_kind == hmbx_pkg::HMBX_REG_STATUS);
      wire logic host_out_rd = host_rd_end && (host_port == 2'(gp)) && ~host_a0;

      // the user bit mask keeps the tag and both flag positions clear, so a
      // controller write of the status byte cannot touch them
      // data, tag and user bits keep their values through any reset
      always_ff @(posedge mclk) begin
        if (here_drain) begin
          input_byte_r[gp]  <= head_data;
          command_tag_r[gp] <= head_tag;
        end
        if (out_wr) begin
          output_byte_r[gp] <= sfr_wdata;
        end
        if (stat_wr) begin
          user_status_r[gp] <= sfr_wdata & hmbx_pkg::STAT_USER_MASK;
        end
      end

      // a controller read racing a drain into the same port cannot occur,
      // as the drain stalls; an output write racing a host read keeps the
      // new byte flagged so the host still sees it
      // set wins over clear on both flags
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          input_full_r[gp]  <= 1'b0;
          output_full_r[gp] <= 1'b0;
        end else begin
          if (here_drain) begin
            input_full_r[gp] <= 1'b1;
          end else if (in_rd) begin
            input_full_r[gp] <= 1'b0;
          end
          if (out_wr) begin
            output_full_r[gp] <= 1'b1;
          end else if (host_out_rd) begin
            output_full_r[gp] <= 1'b0;
          end
        end
      end

      // fixed bits overwrite the masked user byte; no storage of its own
      // assemble the status byte seen by both sides
      always_comb begin
        status_byte[gp]                             = user_status_r[gp];
        status_byte[gp][hmbx_pkg::STAT_COMMAND_TAG] = command_tag_r[gp];
        status_byte[gp][hmbx_pkg::STAT_INPUT_FULL]  = input_full_r[gp];
        status_byte[gp][hmbx_pkg::STAT_OUTPUT_FULL] = output_full_r[gp];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // controller read path
  // ---------------------------------------------------------------
  // unmapped reads return zero rather than an unknown, so firmware
  // probing empty addresses sees a stable value
  logic [DATA_W-1:0] sfr_rdata_nxt;

  always_comb begin
    case (dec_kind)
      hmbx_pkg::HMBX_REG_STATUS: sfr_rdata_nxt = status_byte[dec_port];
      hmbx_pkg::HMBX_REG_INPUT:  sfr_rdata_nxt = input_byte_r[dec_port];
      hmbx_pkg::HMBX_REG_OUTPUT: sfr_rdata_nxt = output_byte_r[dec_port];
      default:                   sfr_rdata_nxt = hmbx_pkg::BYTE_ZERO;
    endcase
  end

  // sfr_rdata holds between reads, so a slow controller may take it late;
  // a read of an input byte clears its flag in the same edge
  // read data lands one edge after the read enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= hmbx_pkg::BYTE_ZERO;
    end else if (sfr_rd_en) begin
      sfr_rdata <= sfr_rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // host read path
  // ---------------------------------------------------------------
  // host_port falls back to the keyboard port when nothing is selected,
  // but the data enable stays low then, so nothing reaches the pins
  // A0 low gives the output byte, high gives status
  wire logic [DATA_W-1:0] host_data_nxt = host_a0 ? status_byte[host_port]
                                                  : output_byte_r[host_port];

  // a flag change during a long strobe shows up in the status byte read
  // resampled each cycle of the strobe; first edge after strobe fall is valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= hmbx_pkg::BYTE_ZERO;
    end else if (host_rd_act) begin
      host_data_out <= host_data_nxt;
    end
  end

  assign host_data_oe = host_rd_act;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // the enables are pins from the controller's own enable register, so
  // masking here changes only the request, never the flag itself
  // only input-full reaches the controller; output-full goes to the host
  assign kbd_input_irq       = input_full_r[hmbx_pkg::PORT_KBD] &
                               kbd_input_irq_enable;
  assign power_one_input_irq = input_full_r[hmbx_pkg::PORT_PWR1] &
                               power_one_input_irq_enable;
  assign power_two_input_irq = input_full_r[hmbx_pkg::PORT_PWR2] &
                               power_two_input_irq_enable;

  // host pins follow the flags directly: the keyboard pin is active
  // high and the two power pins active low, all inactive during reset
  assign kbd_output_full_host_irq_pin = output_full_r[hmbx_pkg::PORT_KBD];
  assign power_one_host_irq_pin_n     = ~output_full_r[hmbx_pkg::PORT_PWR1];
  assign power_two_host_irq_pin_n     = ~output_full_r[hmbx_pkg::PORT_PWR2];

endmodule // hmbx_host_mailbox_ports

`default_nettype wire

/* File: verification/hmbx_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------
// mailbox port checker
// ----------
module hmbx_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       kbd_port_select_n,
  input wire logic       power_one_port_select_n,
  input wire logic       power_two_port_select_n,
  input wire logic       host_a0,
  input wire logic       host_rd_n,
  input wire logic       host_wr_n,
  input wire logic       host_data_oe,
  input wire logic       host_write_ready,
  input wire logic       kbd_output_full_host_irq_pin,
  input wire logic       power_one_host_irq_pin_n,
  input wire logic       power_two_host_irq_pin_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr_en,
  input wire logic       sfr_rd_en,
  input wire logic       kbd_input_irq_enable,
  input wire logic       kbd_input_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // selects as one vector, keyboard alone is 3'h6; ob_wr is a write of the keyboard output byte
  wire [2:0] sel_n = {power_two_port_select_n, power_one_port_select_n, kbd_port_select_n};
  wire       ob_wr = sfr_wr_en && sfr_addr == 8'hAF;
  kbd_out_set_a: assert property (ob_wr |=> kbd_output_full_host_irq_pin)
    else $error("keyboard host pin not raised");
  pwr1_out_set_a: assert property (sfr_wr_en && sfr_addr == 8'hBF |=> !power_one_host_irq_pin_n)
    else $error("power one host pin not lowered");
  pwr2_out_set_a: assert property (sfr_wr_en && sfr_addr == 8'hF7 |=> !power_two_host_irq_pin_n)
    else $error("power two host pin not lowered");
  kbd_host_read_a: assert property ($rose(host_rd_n) && sel_n == 3'h6 && !host_a0 && !ob_wr
    |=> !kbd_output_full_host_irq_pin) else $error("keyboard output full not cleared");
  reset_flags_a: assert property ($rose(rst_n) |-> !kbd_output_full_host_irq_pin && !kbd_input_irq
    && power_one_host_irq_pin_n && power_two_host_irq_pin_n) else $error("flags not reset");
  in_read_clr_a: assert property (sfr_rd_en && sfr_addr == 8'hAE |=> !kbd_input_irq)
    else $error("input full not cleared by read");
  host_write_set_a: assert property ($rose(host_wr_n) && sel_n == 3'h6 && kbd_input_irq_enable
    && host_write_ready && !sfr_rd_en |-> ##[1:3] kbd_input_irq) else $error("input irq missing");
  irq_mask_a: assert property (!kbd_input_irq_enable |-> !kbd_input_irq)
    else $error("masked input irq raised");
  data_drive_a: assert property (host_data_oe == (!host_rd_n && sel_n inside {3'h3, 3'h5, 3'h6}))
    else $error("host data enable wrong");
  no_out_irq_a: assert property (ob_wr && !kbd_input_irq && $past(host_wr_n) && $past(host_wr_n, 2)
    && !$past(sfr_rd_en) |=> !kbd_input_irq) else $error("output write raised input irq");
endmodule // hmbx_chk

bind hmbx_host_mailbox_ports hmbx_chk u_chk (
  .mclk, .rst_n, .kbd_port_select_n, .power_one_port_select_n, .power_two_port_select_n,
  .host_a0, .host_rd_n, .host_wr_n, .host_data_oe, .host_write_ready,
  .kbd_output_full_host_irq_pin, .power_one_host_irq_pin_n, .power_two_host_irq_pin_n,
  .sfr_addr, .sfr_wr_en, .sfr_rd_en, .kbd_input_irq_enable, .kbd_input_irq
);
`default_nettype wire

/* File: verification/hmbx_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------
// host cpu on the parallel bus
// ----------
module hmbx_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] dout,
  output logic      [2:0] sel_n,
  output logic            a0,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] din
);
  // idle bus: nothing selected, both strobes high
  initial begin
    sel_n = 3'h7;
    a0 = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    din = 8'h5A;
  end
  // select, tag and byte stay put past the strobe's trailing edge, where the port samples them
  task automatic wr(input logic [2:0] s, input logic a, input logic [7:0] d);
    @(posedge mclk);
    sel_n <= s;
    a0 <= a;
    din <= d;
    wr_n <= 1'b0;
    repeat (2) @(posedge mclk);
    wr_n <= 1'b1;
    @(posedge mclk);
    sel_n <= 3'h7;
    din <= ~d; // a released bus must not keep showing the byte
    repeat (2) @(posedge mclk);
  endtask
  // read data is taken before the strobe rises
  task automatic rd(input logic [2:0] s, input logic a, output logic [7:0] d);
    @(posedge mclk);
    sel_n <= s;
    a0 <= a;
    rd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    d = dout;
    @(posedge mclk);
    rd_n <= 1'b1;
    @(posedge mclk);
    sel_n <= 3'h7;
    repeat (2) @(posedge mclk);
  endtask
endmodule // hmbx_host_model
`default_nettype wire

/* File: verification/hmbx_host_mailbox_ports_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module hmbx_host_mailbox_ports_bench;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr_en = 1'b0;
  logic       sfr_rd_en = 1'b0;
  logic [2:0] en = 3'h7;
  logic [7:0] s;
  logic [7:0] h;
  logic [7:0] p;
  logic [7:0] b;
  logic [2:0] ps;
  wire  [2:0] sel_n;
  wire        a0, rd_n, wr_n, kpin, p1n, p2n, ki, p1i, p2i, wrdy;
  wire  [7:0] din, dout, sfr_rdata;
  wire  [2:0] pin = {~p2n, ~p1n, kpin};
  wire  [2:0] irq = {p2i, p1i, ki};
  int         errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] base [3] = '{hmbx_pkg::KBD_PORT_STATUS, hmbx_pkg::POWER_PORT_ONE_STATUS,
                           hmbx_pkg::POWER_PORT_TWO_STATUS};
  always #4 mclk = ~mclk;
  hmbx_host_mailbox_ports dut (
    .mclk(mclk), .rst_n(rst_n), .kbd_port_select_n(sel_n[0]),
    .power_one_port_select_n(sel_n[1]), .power_two_port_select_n(sel_n[2]),
    .host_a0(a0), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(), .host_write_ready(wrdy),
    .kbd_output_full_host_irq_pin(kpin), .power_one_host_irq_pin_n(p1n),
    .power_two_host_irq_pin_n(p2n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .kbd_input_irq_enable(en[0]), .power_one_input_irq_enable(en[1]),
    .power_two_input_irq_enable(en[2]), .kbd_input_irq(ki),
    .power_one_input_irq(p1i), .power_two_input_irq(p2i));
  hmbx_host_model host (
    .mclk(mclk), .dout(dout), .sel_n(sel_n), .a0(a0), .rd_n(rd_n), .wr_n(wr_n), .din(din));
  // ----------
  // controller bus, compare and verdict
  // ----------
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_wr_en <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr_en <= 1'b0;
  endtask
  task automatic sr(input logic [7:0] a);
    @(posedge mclk);
    sfr_rd_en <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd_en <= 1'b0;
    @(negedge mclk);
    s = sfr_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      test_done();
    end
  end
  // each port in turn: command, data, user bits, output byte, then a reset in mid-run
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk) chk({7'h00, wrdy}, 8'h01);
    for (p = 8'h00; p < 8'h03; p++) begin
      ps = ~(3'h1 << p[1:0]);
      b = base[p[1:0]];
      sr(b);
      chk(s & 8'h03, 8'h00);
      host.rd(ps, 1'b1, h);
      chk(h & 8'h02, 8'h00);
      host.wr(ps, 1'b1, 8'hA0 + p);
      sr(b);
      chk(s & 8'h0B, 8'h0A);
      chk({7'h00, irq[p[1:0]]}, 8'h01);
      @(posedge mclk) en[p[1:0]] <= 1'b0;
      @(negedge mclk) chk({7'h00, irq[p[1:0]]}, 8'h00);
      @(posedge mclk) en[p[1:0]] <= 1'b1;
      sw(b + 8'h01, 8'h55);
      sr(b + 8'h01);
      chk(s, 8'hA0 + p);
      sr(b);
      chk(s & 8'h0B, 8'h08);
      host.wr(ps, 1'b0, 8'h5A);
      sr(b + 8'h01);
      chk(s, 8'h5A);
      sw(b, 8'hFF);
      sr(b);
      chk(s, 8'hF4);
      host.rd(ps, 1'b1, h);
      chk(h, 8'hF4);
      sw(b + 8'h02, 8'hC3 + p);
      sr(b);
      chk(s, 8'hF5);
      chk({7'h00, pin[p[1:0]]}, 8'h01);
      host.rd(ps, 1'b0, h);
      chk(h, 8'hC3 + p);
      chk({7'h00, pin[p[1:0]]}, 8'h00);
    end
    sw(8'hAF, 8'h77);
    host.wr(3'h6, 1'b1, 8'h11);
    @(posedge mclk) rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    sr(8'hAD);
    chk(s, 8'hFC);
    sr(8'hAF);
    chk(s, 8'h77);
    host.wr(3'h4, 1'b0, 8'hEE);
    sr(8'hAD);
    chk(s, 8'hFC);
    sr(8'hAE);
    chk(s, 8'h11);
    sw(8'h00, 8'hFF);
    sr(8'h00);
    chk(s, 8'h00);
    test_done();
  end
endmodule // hmbx_host_mailbox_ports_bench
`default_nettype wire
